// ### lpm_consts.vh
// Constants for the low-power mode controller.
// Assumes inclusion by bare name from the design file.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
`define MODE_W 2
`define MODE_IDLE 2'h0
`define MODE_STANDBY 2'h1
`define HALT_BIT 1
`define QUAL_W 6
`define QUAL_RESET 6'h02
`define WAKE_W 18
`define WAKE_SEL_RESET 18'h00000
`define ST_NORMAL 2'h0
`define ST_IDLE 2'h1
`define ST_STANDBY 2'h2
`define ST_HALT 2'h3
`define SYNC_W 3
`endif

// ### low_power_mode_controller.v
// Low-power mode controller: mode decode, clock gating and wake qualification.
// Assumes one clock, sys_clk, standing in for the oscillator clock, and a synchronous reset.
//
// Summary of operation
// - Mode field 0,0 is idle, 0,1 is standby and 1,X is halt; standby stops core and system clock.
// - In idle the system clock output keeps running.
// - Idle ends on an enabled interrupt, the nonmaskable interrupt, reset, watchdog or debugger.
// - In idle the controller ends the mode on the interrupt path or on its own reset, watchdog, debugger and, with nmi_enable set, NMI wakes.
// - Software selects the standby wake sources; reset and the debugger are honoured regardless.
// - Standby accepts reset, watchdog, interrupt one, NMI, trips, serial, CAN and debugger.
// - A selected standby wake must stay low for one more than the programmed number of oscillator cycles; with a zero count the code needs two.
// - Halt turns off oscillator and PLL, so core clock, system clock and watchdog stop.
// - Halt wakes only on external reset, the NMI input or the debugger.
// - The NMI input to the core has its own enable so it can wake from halt safely.
// - A low level on a listed wake signal is the wake condition.
// - A wake too short to be recognised returns the device to the same low-power mode.
// - Low-power entry and exit leave output pins at the level software last drove.
// - The debug port stays usable while the core clock is stopped.
// - In standby the watchdog runs on the oscillator and its wake feeds the controller.
`include "lpm_consts.vh"
module low_power_mode_controller (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] low_power_mode_field,
    input wire [5:0] low_power_ctrl_reg0,
    input wire [17:0] wake_source_select_reg,
    input wire nmi_enable,
    input wire idle_instr,
    input wire irq_recognized,
    input wire external_reset_n,
    input wire nonmaskable_irq_pin,
    input wire watchdog_wake_irq,
    input wire ext_irq_line_one,
    input wire [5:0] timer_trip_inputs,
    input wire [5:0] compare_trip_inputs,
    input wire serial_rx_a,
    input wire serial_rx_b,
    input wire can_receive_pin,
    input wire debugger_wake_n,
    input wire [7:0] pin_out_sw,
    output reg oscillator_clock_en,
    output reg core_clock_input_en,
    output reg system_clock_out_en,
    output reg watchdog_clock_en,
    output reg debug_port_en,
    output reg nmi_to_core_n,
    output reg wake_event,
    output reg [1:0] lpm_state,
    output reg [7:0] pin_out
);
    localparam NWAKE = 19;

    // Wake lines: 0 reset, 1 watchdog, 2 irq one, 3 NMI, 4-9 timer trips,
    // 10-15 compare trips, 16 serial a, 17 serial b, 18 CAN; debugger is separate.
    wire [NWAKE-1:0] raw_wake;
    assign raw_wake = {can_receive_pin, serial_rx_b, serial_rx_a, compare_trip_inputs,
                       timer_trip_inputs, nonmaskable_irq_pin, ext_irq_line_one,
                       watchdog_wake_irq, external_reset_n};

    reg [NWAKE-1:0] s1, s2, s3;
    reg [NWAKE-1:0] wake_level;
    reg dbg1, dbg2, dbg3, dbg_level;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`QUAL_W-1:0] qual_cnt;
    reg qualifying;

    function is_low;
        input [NWAKE-1:0] lv;
        input [NWAKE-1:0] sel;
        begin
            is_low = |(~lv & sel);
        end
    endfunction

    // Three-stage synchronisers; a level changes once stages two and three agree.
    always @(posedge sys_clk) begin
        if (rst) begin
            s1 <= {NWAKE{1'b1}};
            s2 <= {NWAKE{1'b1}};
            s3 <= {NWAKE{1'b1}};
            wake_level <= {NWAKE{1'b1}};
            dbg1 <= 1'b1;
            dbg2 <= 1'b1;
            dbg3 <= 1'b1;
            dbg_level <= 1'b1;
        end else begin
            s1 <= raw_wake;
            s2 <= s1;
            s3 <= s2;
            wake_level <= (s2 & s3) | (wake_level & (s2 ^ s3));
            dbg1 <= debugger_wake_n;
            dbg2 <= dbg1;
            dbg3 <= dbg2;
            dbg_level <= (dbg2 & dbg3) | (dbg_level & (dbg2 ^ dbg3));
        end
    end

    // Standby selection: reset always, the rest per select register bits 0..17.
    wire [NWAKE-1:0] standby_sel;
    assign standby_sel = {wake_source_select_reg, 1'b1};
    wire [NWAKE-1:0] halt_sel;
    assign halt_sel = {{(NWAKE-4){1'b0}}, nmi_enable, 2'b00, 1'b1};

    wire standby_low;
    assign standby_low = is_low(wake_level, standby_sel);
    wire halt_wake;
    assign halt_wake = is_low(wake_level, halt_sel) | ~dbg_level;
    wire idle_wake;
    // Idle exit comes from the interrupt path; reset, watchdog and debugger also end it.
    assign idle_wake = irq_recognized | ~wake_level[0] | ~wake_level[1] | ~dbg_level
                       | (nmi_enable & ~wake_level[3]);

    always @* begin
        next_state = state;
        case (state)
            `ST_NORMAL: begin
                if (idle_instr) begin
                    if (low_power_mode_field[`HALT_BIT]) begin
                        next_state = `ST_HALT;
                    end else if (low_power_mode_field == `MODE_STANDBY) begin
                        next_state = `ST_STANDBY;
                    end else begin
                        next_state = `ST_IDLE;
                    end
                end
            end
            `ST_IDLE: begin
                if (idle_wake) begin
                    next_state = `ST_NORMAL;
                end
            end
            `ST_STANDBY: begin
                // Qualified wake; a pulse shorter than the count leaves standby held.
                if (~dbg_level || (qualifying && standby_low && qual_cnt >= low_power_ctrl_reg0)) begin
                    next_state = `ST_NORMAL;
                end
            end
            `ST_HALT: begin
                if (halt_wake) begin
                    next_state = `ST_NORMAL;
                end
            end
            default: begin
                next_state = `ST_NORMAL;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state <= `ST_NORMAL;
            qual_cnt <= {`QUAL_W{1'b0}};
            qualifying <= 1'b0;
        end else begin
            state <= next_state;
            if (state == `ST_STANDBY && standby_low) begin
                qualifying <= 1'b1;
                if (qual_cnt != {`QUAL_W{1'b1}}) begin
                    qual_cnt <= qual_cnt + 6'h01;
                end
            end else begin
                qualifying <= 1'b0;
                qual_cnt <= {`QUAL_W{1'b0}};
            end
        end
    end

    // Clock gating and status outputs, all registered.
    always @(posedge sys_clk) begin
        if (rst) begin
            oscillator_clock_en <= 1'b1;
            core_clock_input_en <= 1'b1;
            system_clock_out_en <= 1'b1;
            watchdog_clock_en <= 1'b1;
            debug_port_en <= 1'b1;
            nmi_to_core_n <= 1'b1;
            wake_event <= 1'b0;
            lpm_state <= `ST_NORMAL;
            pin_out <= 8'h00;
        end else begin
            oscillator_clock_en <= (next_state != `ST_HALT);
            watchdog_clock_en <= (next_state != `ST_HALT);
            core_clock_input_en <= (next_state == `ST_NORMAL) || (next_state == `ST_IDLE);
            system_clock_out_en <= (next_state == `ST_NORMAL) || (next_state == `ST_IDLE);
            debug_port_en <= 1'b1;
            nmi_to_core_n <= ~nmi_enable | wake_level[3];
            wake_event <= (state != `ST_NORMAL) && (next_state == `ST_NORMAL);
            lpm_state <= next_state;
            if (state == `ST_NORMAL && next_state == `ST_NORMAL) begin
                pin_out <= pin_out_sw;
            end
        end
    end
endmodule // low_power_mode_controller

// ### lpm_props.sv
// Checker for the low-power mode controller, watching its ports only.
// Assumes one clock, sys_clk, and a synchronous active-high reset.
module lpm_props (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] low_power_mode_field,
    input wire idle_instr,
    input wire external_reset_n,
    input wire nonmaskable_irq_pin,
    input wire debugger_wake_n,
    input wire nmi_enable,
    input wire oscillator_clock_en,
    input wire core_clock_input_en,
    input wire system_clock_out_en,
    input wire watchdog_clock_en,
    input wire debug_port_en,
    input wire nmi_to_core_n,
    input wire wake_event,
    input wire [1:0] lpm_state,
    input wire [7:0] pin_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire [3:0] en = {oscillator_clock_en, core_clock_input_en, system_clock_out_en, watchdog_clock_en};
    a_mode_decode: assert property (lpm_state == 2'h0 && idle_instr |=> lpm_state ==
        ($past(low_power_mode_field[1]) ? 2'h3 :
        {$past(low_power_mode_field[0]), ~$past(low_power_mode_field[0])}))
        else $error("mode decode wrong");
    a_no_entry: assert property (lpm_state == 2'h0 && !idle_instr |=> lpm_state == 2'h0)
        else $error("mode entered without idle instruction");
    a_idle_clocks: assert property (lpm_state == 2'h1 |-> en == 4'hF)
        else $error("clock stopped in idle");
    a_standby_clocks: assert property (lpm_state == 2'h2 |-> en == 4'h9)
        else $error("standby clock gating wrong");
    a_halt_clocks: assert property (lpm_state == 2'h3 |-> en == 4'h0)
        else $error("halt clock gating wrong");
    a_debug_alive: assert property (debug_port_en)
        else $error("debug port disabled");
    a_pins_frozen: assert property (lpm_state != 2'h0 |=> $stable(pin_out))
        else $error("pin changed in low power");
    a_wake_return: assert property (wake_event |-> lpm_state == 2'h0 && $past(lpm_state) != 2'h0)
        else $error("wake event without return");
    a_halt_ignores: assert property ((lpm_state == 2'h3 && external_reset_n && nonmaskable_irq_pin
        && debugger_wake_n)[*6] |=> lpm_state == 2'h3) else $error("halt left without wake");
    a_nmi_gated: assert property (!nmi_enable && $past(!nmi_enable) |-> nmi_to_core_n)
        else $error("nmi passed while disabled");
    cover property (lpm_state == 2'h1 ##1 wake_event);
    cover property (lpm_state == 2'h2 ##1 wake_event);
    cover property (lpm_state == 2'h3 ##1 wake_event);
endmodule // lpm_props
bind low_power_mode_controller lpm_props i_lpm_props (.sys_clk, .rst, .low_power_mode_field,
    .idle_instr, .external_reset_n, .nonmaskable_irq_pin, .debugger_wake_n, .nmi_enable,
    .oscillator_clock_en, .core_clock_input_en, .system_clock_out_en, .watchdog_clock_en,
    .debug_port_en, .nmi_to_core_n, .wake_event, .lpm_state, .pin_out);

// ### wake_source_model.sv
// Model of the wake sources; every line idles high behind a pull-up.
// Assumes requests are raised between clock edges.
module wake_source_model (
    input wire sys_clk,
    input wire req,
    input wire [4:0] line,
    input wire [7:0] len,
    output logic [19:0] wake_n
);
    logic [7:0] left = 8'h00;
    initial wake_n = 20'hFFFFF;
    always @(posedge sys_clk) begin
        if (req) begin
            left <= len;
            wake_n <= ~(20'h00001 << line);
        end else if (left > 8'h01) begin
            left <= left - 8'h01;
        end else begin
            wake_n <= 20'hFFFFF;
        end
    end
endmodule // wake_source_model

// ### tb_top.sv
// Testbench for the low-power mode controller: entry, clock gating, pins and wake-up.
// Assumes the design, its constants header and the wake source model are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, nmi_en = 0, idle = 0, irq = 0, req = 0, w;
    logic [1:0] field = 2'h0;
    logic [17:0] sel = 18'h00001;
    logic [7:0] pin_sw = 8'hA5, len = 8'h00;
    logic [4:0] line = 5'h00;
    logic [19:0] wk;
    wire osc, core, sys, wd, dbg, nmi_n, wev;
    wire [1:0] st;
    wire [7:0] pins;
    wire [7:0] en = {3'h0, osc, core, sys, wd, dbg};
    int num_errors = 0, checks = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    wake_source_model i_wake_source_model (.sys_clk(sys_clk), .req(req), .line(line), .len(len),
        .wake_n(wk));
    low_power_mode_controller i_low_power_mode_controller (.sys_clk(sys_clk), .rst(rst),
        .low_power_mode_field(field), .low_power_ctrl_reg0(6'h04), .wake_source_select_reg(sel),
        .nmi_enable(nmi_en), .idle_instr(idle), .irq_recognized(irq), .external_reset_n(wk[0]),
        .nonmaskable_irq_pin(wk[1]), .watchdog_wake_irq(wk[2]), .ext_irq_line_one(wk[3]),
        .timer_trip_inputs(wk[9:4]), .compare_trip_inputs(wk[15:10]), .serial_rx_a(wk[16]),
        .serial_rx_b(wk[17]), .can_receive_pin(wk[18]), .debugger_wake_n(wk[19]),
        .pin_out_sw(pin_sw), .oscillator_clock_en(osc), .core_clock_input_en(core),
        .system_clock_out_en(sys), .watchdog_clock_en(wd), .debug_port_en(dbg),
        .nmi_to_core_n(nmi_n), .wake_event(wev), .lpm_state(st), .pin_out(pins));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic enter(input logic [1:0] m);
        @(negedge sys_clk);
        field = m;
        idle = 1;
        @(negedge sys_clk);
        idle = 0;
    endtask
    // Holds one wake line low for n cycles and notes whether the core came back.
    task automatic pulse(input int k, input int n);
        @(negedge sys_clk);
        line = k[4:0];
        len = n[7:0];
        req = 1;
        @(negedge sys_clk);
        req = 0;
        w = 0;
        repeat (n + 40) @(negedge sys_clk) if (wev === 1'b1) w = 1;
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        rst = 0;
        repeat (4) @(negedge sys_clk);
        chk("reset enables", 8'h1F, en);
        enter(2'h0);
        chk("idle state", 8'h01, {6'h00, st});
        pin_sw = 8'h3C;
        repeat (3) @(negedge sys_clk);
        chk("idle enables", 8'h1F, en);
        chk("idle pins", 8'hA5, pins);
        irq = 1;
        @(negedge sys_clk);
        irq = 0;
        chk("idle exit", 8'h00, {6'h00, st});
        enter(2'h1);
        chk("standby enables", 8'h13, en);
        pulse(2, 2);
        chk("short wake", 8'h00, {7'h0, w});
        pulse(3, 20);
        chk("unselected wake", 8'h00, {7'h0, w});
        pulse(2, 20);
        chk("watchdog wake", 8'h01, {7'h0, w});
        nmi_en = 1;
        sel = 18'h3FFFF;
        for (int k = 0; k < 20; k++) begin
            enter(2'h1);
            pulse(k, 20);
            chk("standby source", 8'h01, {7'h0, w});
        end
        for (int k = 0; k < 20; k++) begin
            enter({1'b1, k[0]});
            chk("halt enables", 8'h01, en);
            pulse(k, 20);
            chk("halt wake", {7'h0, k < 2 || k == 19}, {7'h0, w});
        end
        nmi_en = 0;
        enter(2'h3);
        pulse(1, 20);
        chk("masked nmi", 8'h01, {7'h0, ~w & nmi_n});
        give_verdict();
    end
endmodule // tb_top
